// >>> verilog/mss_defs.svh
// constants for the multi-step speed sequencer: offsets, fields, resets, timing
// assumes one 50 MHz system clock and register indices as word addresses
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

// register indices
`define MSS_OFS_MODE       8'h00
`define MSS_OFS_RETAIN     8'h01
`define MSS_OFS_STEP_BASE  8'h02
`define MSS_OFS_STEP_LAST  8'h21
`define MSS_OFS_TUNIT      8'h25
`define MSS_OFS_FMAX       8'h40
`define MSS_OFS_CTRL       8'h41
`define MSS_OFS_STATUS     8'h42

// control register bits (write only, self clearing)
`define MSS_CTRL_RUN_BIT   0
`define MSS_CTRL_STOP_BIT  1

// status register fields
`define MSS_STAT_STEP_LSB  0
`define MSS_STAT_RUN_BIT   4
`define MSS_STAT_HOLD_BIT  5
`define MSS_STAT_RES_BIT   6
`define MSS_STAT_LOSS_BIT  7

// mode codes in the low two bits of the mode register
`define MSS_MODE_ONCE      2'h0
`define MSS_MODE_HOLD      2'h1

// reset values
`define MSS_MODE_RST       16'h0000
`define MSS_RETAIN_RST     16'h0000
`define MSS_TUNIT_RST      16'h0000
`define MSS_STEP_RST       16'h0000
`define MSS_FMAX_RST       16'h1388

// speed limits in 0.1 % units, and the 100 % figure
`define MSS_SPEED_MAX      16'sh0BB8
`define MSS_SPEED_MIN      -16'sh0BB8
`define MSS_SPEED_FULL     28'h00003E8

// timing: clock rate and the length of one running-time unit, then the last step index
`define MSS_CLK_HZ         50000000
`define MSS_TENTH_SEC_MS   100
`define MSS_TENTH_MIN_MS   6000
`define MSS_LAST_STEP      4'hF

`endif

// >>> verilog/mss_pkg.sv
// types shared by the multi-step speed sequencer files
// assumes mss_defs.svh for all numeric constants
package mss_pkg;

    typedef logic [7:0]  mss_addr_t;
    typedef logic [15:0] mss_word_t;
    typedef logic [17:0] mss_freq_t;

    typedef enum logic [2:0] {
        MSS_IDLE = 3'b001,
        MSS_RUN  = 3'b010,
        MSS_HOLD = 3'b100
    } mss_state_t;

endpackage

// >>> verilog/mss_tick.sv
// time base for step running times: one pulse per tenth of a second or minute
// assumes en low resets the phase so each step starts a full unit
`timescale 1ns/1ns
`include "mss_defs.svh"
module mss_tick #(
    parameter int unsigned TENTH_SEC_CYC = 5000000,
    parameter int unsigned TENTH_MIN_CYC = 300000000
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic en,
    input  wire logic unit_min,
    output logic      tick
);
    import mss_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } mss_tick_st_t;

    mss_tick_st_t s_r;
    mss_tick_st_t s_nxt;
    logic [31:0]  limit;

    always_comb begin
        s_nxt = s_r;
        limit = unit_min ? 32'(TENTH_MIN_CYC - 1) : 32'(TENTH_SEC_CYC - 1);
        s_nxt.tick = 1'b0;
        if (!en) begin
            s_nxt.cnt = 32'h0;
        end else if (s_r.cnt >= limit) begin
            s_nxt.cnt = 32'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule

// >>> verilog/mss_seq.sv
// multi-step speed sequencer: sixteen steps of speed and time, three end modes
// assumes a plain register port, an asynchronous power-loss pin, 50 MHz sys_clk
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
`include "mss_defs.svh"
// Summary of operation
// - in once mode, stop the drive by itself after one full cycle.
// - after that stop, wait for a fresh run command before starting again.
// - in hold mode, keep last step frequency and direction after one cycle.
// - in cyclic mode, wrap to step 0 after each cycle until stop arrives.
// - retention 1 keeps step and frequency over power loss; 0 discards them.
// - speed accepts -300.0..300.0 %, scaled so 100 % is max output frequency.
// - sixteen steps 0..15, each with its own speed and running time.
// - running time 0.0..6553.5 tenths, seconds or minutes by unit select.
// - direction follows the sign of the step speed; negative runs reverse.
module mss_seq #(
    parameter int unsigned TENTH_SEC_CYC = `MSS_CLK_HZ / 1000 * `MSS_TENTH_SEC_MS,
    parameter int unsigned TENTH_MIN_CYC = `MSS_CLK_HZ / 1000 * `MSS_TENTH_MIN_MS
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire mss_pkg::mss_addr_t addr,
    input  wire mss_pkg::mss_word_t wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output mss_pkg::mss_word_t     rd_data,
    input  wire logic              pwr_loss,
    output mss_pkg::mss_freq_t     freq_ref,
    output logic                   rev_dir,
    output logic                   drive_run
);
    import mss_pkg::*;

    typedef struct packed {
        mss_state_t                st;
        mss_word_t                 mode;
        mss_word_t                 retain;
        mss_word_t                 tunit;
        mss_word_t                 fmax;
        logic [15:0][15:0]         speed;
        logic [15:0][15:0]         dur;
        logic [3:0]                step;
        mss_word_t                 elapsed;
        logic                      resume;
        mss_freq_t                 freq;
        logic                      rev;
        logic                      run;
        mss_word_t                 rdata;
        logic [2:0]                pwr_sync;
    } mss_seq_st_t;

    mss_seq_st_t s_r;
    mss_seq_st_t s_nxt;
    logic        tick;
    logic        adv;
    logic        run_wr;
    logic        stop_wr;
    logic        lost;
    logic        lost_evt;
    logic [3:0]  wr_idx;

    // step table decode, shared by the write and read paths
    function automatic logic is_step(input mss_addr_t a);
        is_step = (a >= `MSS_OFS_STEP_BASE) && (a <= `MSS_OFS_STEP_LAST);
    endfunction

    function automatic logic [3:0] step_of(input mss_addr_t a);
        mss_addr_t d;
        d = a - `MSS_OFS_STEP_BASE;
        step_of = d[4:1];
    endfunction

    // out-of-range setpoints are clipped rather than refused
    function automatic mss_word_t clamp_speed(input mss_word_t v);
        if ($signed(v) > `MSS_SPEED_MAX) begin
            clamp_speed = 16'(`MSS_SPEED_MAX);
        end else if ($signed(v) < `MSS_SPEED_MIN) begin
            clamp_speed = 16'(`MSS_SPEED_MIN);
        end else begin
            clamp_speed = v;
        end
    endfunction

    // magnitude times fmax over 100.0 %; divide by a constant, one cycle
    function automatic mss_freq_t scale(input mss_word_t sp, input mss_word_t fm);
        logic [15:0] mag;
        logic [27:0] prod;
        mag = sp[15] ? 16'(-sp) : sp;
        prod = 28'(mag) * 28'(fm);
        scale = 18'(prod / `MSS_SPEED_FULL);
    endfunction

    mss_tick #(
        .TENTH_SEC_CYC (TENTH_SEC_CYC),
        .TENTH_MIN_CYC (TENTH_MIN_CYC)
    ) u_tick (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .en       ((s_r.st == MSS_RUN) && !adv),
        .unit_min (s_r.tunit[0]),
        .tick     (tick)
    );

    assign run_wr   = wr_en && (addr == `MSS_OFS_CTRL) && wr_data[`MSS_CTRL_RUN_BIT];
    assign stop_wr  = wr_en && (addr == `MSS_OFS_CTRL) && wr_data[`MSS_CTRL_STOP_BIT];
    assign lost     = s_r.pwr_sync[1];
    assign lost_evt = s_r.pwr_sync[1] && !s_r.pwr_sync[2];
    assign adv      = (s_r.st == MSS_RUN) && (s_r.elapsed >= s_r.dur[s_r.step]);
    assign wr_idx   = step_of(addr);

    always_comb begin
        s_nxt = s_r;
        s_nxt.pwr_sync = {s_r.pwr_sync[1:0], pwr_loss};

        // register writes
        if (wr_en) begin
            if (addr == `MSS_OFS_MODE) begin
                s_nxt.mode = wr_data;
            end
            if (addr == `MSS_OFS_RETAIN) begin
                s_nxt.retain = wr_data;
            end
            if (addr == `MSS_OFS_TUNIT) begin
                s_nxt.tunit = wr_data;
            end
            if (addr == `MSS_OFS_FMAX) begin
                s_nxt.fmax = wr_data;
            end
            if (is_step(addr)) begin
                if (addr[0]) begin
                    s_nxt.dur[step_of(addr)] = wr_data;
                end else begin
                    s_nxt.speed[step_of(addr)] = clamp_speed(wr_data);
                end
            end
        end

        // register reads, data in the following cycle only
        s_nxt.rdata = 16'h0;
        if (rd_en) begin
            if (addr == `MSS_OFS_MODE) begin
                s_nxt.rdata = s_r.mode;
            end else if (addr == `MSS_OFS_RETAIN) begin
                s_nxt.rdata = s_r.retain;
            end else if (addr == `MSS_OFS_TUNIT) begin
                s_nxt.rdata = s_r.tunit;
            end else if (addr == `MSS_OFS_FMAX) begin
                s_nxt.rdata = s_r.fmax;
            end else if (is_step(addr)) begin
                s_nxt.rdata = addr[0] ? s_r.dur[step_of(addr)] : s_r.speed[step_of(addr)];
            end else if (addr == `MSS_OFS_STATUS) begin
                s_nxt.rdata[`MSS_STAT_STEP_LSB +: 4] = s_r.step;
                s_nxt.rdata[`MSS_STAT_RUN_BIT]  = (s_r.st == MSS_RUN);
                s_nxt.rdata[`MSS_STAT_HOLD_BIT] = (s_r.st == MSS_HOLD);
                s_nxt.rdata[`MSS_STAT_RES_BIT]  = s_r.resume;
                s_nxt.rdata[`MSS_STAT_LOSS_BIT] = lost;
            end
        end

        // sequencing
        unique case (s_r.st)
            MSS_IDLE: begin
                if (run_wr && !lost) begin
                    s_nxt.st = MSS_RUN;
                    s_nxt.resume = 1'b0;
                    if (!s_r.resume) begin
                        s_nxt.step = 4'h0;
                        s_nxt.elapsed = 16'h0;
                    end
                end
            end
            MSS_RUN: begin
                if (adv) begin
                    s_nxt.elapsed = 16'h0;
                    if (s_r.step == `MSS_LAST_STEP) begin
                        if (s_r.mode[1:0] == `MSS_MODE_ONCE) begin
                            s_nxt.st = MSS_IDLE;
                            s_nxt.step = 4'h0;
                        end else if (s_r.mode[1:0] == `MSS_MODE_HOLD) begin
                            s_nxt.st = MSS_HOLD;
                        end else begin
                            s_nxt.step = 4'h0;
                        end
                    end else begin
                        s_nxt.step = s_r.step + 4'h1;
                    end
                end else if (tick) begin
                    s_nxt.elapsed = s_r.elapsed + 16'h1;
                end
            end
            MSS_HOLD: begin
                s_nxt.st = MSS_HOLD;
            end
        endcase

        if (stop_wr) begin
            s_nxt.st = MSS_IDLE;
            s_nxt.step = 4'h0;
            s_nxt.elapsed = 16'h0;
            s_nxt.resume = 1'b0;
            // a stop drops a retained frequency too, so idle after a stop shows no stale value, unless a power loss with retention on lands in the same cycle and keeps it
            s_nxt.freq = 18'h0;
            s_nxt.rev = 1'b0;
        end

        // frequency and direction follow the step being run
        if (s_r.st == MSS_RUN) begin
            s_nxt.freq = scale(s_r.speed[s_r.step], s_r.fmax);
            s_nxt.rev = s_r.speed[s_r.step][15];
        end
        if (s_nxt.st == MSS_IDLE && s_r.st != MSS_IDLE) begin
            s_nxt.freq = 18'h0;
            s_nxt.rev = 1'b0;
        end

        // power loss: retained state resumes at the next run command
        if (lost_evt) begin
            s_nxt.st = MSS_IDLE;
            if (s_r.retain[0]) begin
                s_nxt.resume = 1'b1;
                s_nxt.step = s_r.step;
                s_nxt.elapsed = s_r.elapsed;
                s_nxt.freq = s_r.freq;
                s_nxt.rev = s_r.rev;
            end else begin
                s_nxt.resume = 1'b0;
                s_nxt.step = 4'h0;
                s_nxt.elapsed = 16'h0;
                s_nxt.freq = 18'h0;
                s_nxt.rev = 1'b0;
            end
        end
        s_nxt.run = (s_nxt.st != MSS_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.st <= MSS_IDLE;
            s_r.mode <= `MSS_MODE_RST;
            s_r.retain <= `MSS_RETAIN_RST;
            s_r.tunit <= `MSS_TUNIT_RST;
            s_r.fmax <= `MSS_FMAX_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data   = s_r.rdata;
    assign freq_ref  = s_r.freq;
    assign rev_dir   = s_r.rev;
    assign drive_run = s_r.run;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_once_stop: assert property (
        (s_r.st == MSS_RUN && adv && s_r.step == 4'hF && s_r.mode[1:0] == 2'h0
            && !stop_wr && !lost_evt) |=> (s_r.st == MSS_IDLE && !drive_run))
        else $error("once mode did not stop after last step");

    a_idle_wait: assert property (
        (s_r.st == MSS_IDLE && !run_wr) |=> (s_r.st == MSS_IDLE))
        else $error("sequence left idle without a run command");

    a_hold_last: assert property (
        (s_r.st == MSS_HOLD && !stop_wr && !lost_evt) |=>
            (s_r.st == MSS_HOLD && $stable(freq_ref) && $stable(rev_dir) && drive_run))
        else $error("hold mode lost its final frequency");

    a_cyclic_wrap: assert property (
        (s_r.st == MSS_RUN && adv && s_r.step == 4'hF && s_r.mode[1:0] > 2'h1
            && !stop_wr && !lost_evt) |=> (s_r.st == MSS_RUN && s_r.step == 4'h0))
        else $error("cyclic mode did not wrap to step 0");

    a_stop_cmd: assert property (
        (stop_wr && !lost_evt) |=> (s_r.st == MSS_IDLE && !drive_run && freq_ref == 18'h0))
        else $error("stop command did not stop the drive");

    a_retain_keep: assert property (
        (lost_evt && s_r.retain[0]) |=> ($stable(s_r.step) && $stable(freq_ref) && s_r.resume))
        else $error("retained step or frequency changed at power loss");

    a_retain_drop: assert property (
        (lost_evt && !s_r.retain[0]) |=> (s_r.step == 4'h0 && freq_ref == 18'h0 && !s_r.resume))
        else $error("unretained state survived power loss");

    a_freq_scale: assert property (
        (s_r.st == MSS_RUN && !lost_evt && !stop_wr && !(adv && s_r.step == 4'hF)) |=>
            (freq_ref == scale($past(s_r.speed[s_r.step]), $past(s_r.fmax))))
        else $error("output frequency not scaled from step speed");

    a_dir_sign: assert property (
        (s_r.st == MSS_RUN && !lost_evt && !stop_wr && !(adv && s_r.step == 4'hF)) |=>
            (rev_dir == $past(s_r.speed[s_r.step][15])))
        else $error("direction does not follow speed sign");

    a_step_adv: assert property (
        (adv && s_r.step != 4'hF && !stop_wr && !lost_evt) |=>
            (s_r.step == $past(s_r.step) + 4'h1 && s_r.elapsed == 16'h0))
        else $error("step did not advance at its running time");

    a_time_count: assert property (
        (s_r.st == MSS_RUN && !adv && tick && !stop_wr && !lost_evt) |=>
            (s_r.elapsed == $past(s_r.elapsed) + 16'h1))
        else $error("elapsed time not counted on tick");

    a_run_start: assert property (
        (s_r.st == MSS_IDLE && run_wr && !stop_wr && !lost) |=>
            (s_r.st == MSS_RUN && drive_run))
        else $error("run command did not start the sequence");

    a_run_refused: assert property (
        (s_r.st == MSS_IDLE && lost) |=> (s_r.st == MSS_IDLE && !drive_run))
        else $error("sequence started while power was lost");

    a_resume_run: assert property (
        (s_r.st == MSS_IDLE && s_r.resume && run_wr && !stop_wr && !lost) |=>
            (s_r.st == MSS_RUN && s_r.step == $past(s_r.step)))
        else $error("retained step not resumed by run command");

    a_once_zero: assert property (
        (s_r.st == MSS_RUN && adv && s_r.step == 4'hF && s_r.mode[1:0] == 2'h0
            && !lost_evt) |=> (freq_ref == 18'h0 && !rev_dir))
        else $error("once mode left a frequency on the output");

    // register writes: what is stored stays inside the legal range
    a_speed_clip: assert property (
        (wr_en && is_step(addr) && !addr[0]) |=>
            ($signed(s_r.speed[$past(wr_idx)]) <= `MSS_SPEED_MAX
                && $signed(s_r.speed[$past(wr_idx)]) >= `MSS_SPEED_MIN))
        else $error("step speed stored outside its range");

    a_dur_load: assert property (
        (wr_en && is_step(addr) && addr[0]) |=> (s_r.dur[$past(wr_idx)] == $past(wr_data)))
        else $error("step running time not stored as written");

    c_once_end: cover property (s_r.st == MSS_RUN ##1 s_r.st == MSS_IDLE && !stop_wr);
    c_hold_end: cover property (s_r.st == MSS_RUN ##1 s_r.st == MSS_HOLD);
    c_wrap: cover property (s_r.step == 4'hF && adv ##1 s_r.step == 4'h0 && drive_run);
    c_resume: cover property (s_r.resume && run_wr ##1 s_r.st == MSS_RUN);
    c_power_loss: cover property (lost_evt ##1 s_r.resume);
endmodule

// >>> sim/tb_multi_step_speed_sequencer.sv
// self-checking bench for the multi-step speed sequencer
// assumes mss_seq with a shortened time base: 4 cycles a tenth second, 8 a tenth minute
`timescale 1ns/1ns
`include "mss_defs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_multi_step_speed_sequencer;
    import mss_pkg::*;
    logic      sys_clk      = 1'b0;
    logic      sys_rst      = 1'b1;
    mss_addr_t addr         = 8'h00;
    mss_word_t wr_data      = 16'h0000;
    logic      wr_en        = 1'b0;
    logic      rd_en        = 1'b0;
    logic      pwr_loss     = 1'b0;
    mss_word_t rd_data;
    mss_freq_t freq_ref;
    logic      rev_dir;
    logic      drive_run;
    mss_word_t rv;
    int        bad_count    = 0;
    int        total_checks = 0;
    int        cycles       = 0;

    mss_seq #(.TENTH_SEC_CYC(4), .TENTH_MIN_CYC(8)) dut (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .addr      (addr),
        .wr_data   (wr_data),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .rd_data   (rd_data),
        .pwr_loss  (pwr_loss),
        .freq_ref  (freq_ref),
        .rev_dir   (rev_dir),
        .drive_run (drive_run)
    );

    always #10 sys_clk = ~sys_clk;

    task automatic end_of_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a hung wait ends the run here rather than stalling forever
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // every bus task returns 1 ns after an edge, so outputs are settled
    task automatic wr(input mss_addr_t a, input mss_word_t d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        #1;
    endtask

    task automatic rd(input mss_addr_t a);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 rv = rd_data;
    endtask

    task automatic chk_rd(input mss_addr_t a, input mss_word_t e);
        rd(a);
        `CHK("rd_data", e, rv)
    endtask

    task automatic wait_out(input mss_freq_t f, input logic r, input int n);
        int i;
        i = 0;
        while (i < n && !(freq_ref === f && rev_dir === r)) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        `CHK("freq_ref", f, freq_ref)
        `CHK("rev_dir", r, rev_dir)
    endtask

    task automatic wait_run(input logic v, input int n);
        int i;
        i = 0;
        while (i < n && drive_run !== v) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        `CHK("drive_run", v, drive_run)
    endtask

    task automatic run_cmd();
        wr(`MSS_OFS_CTRL, 16'h0001);
        @(posedge sys_clk);
        #1;
    endtask

    task automatic stop_chk();
        wr(`MSS_OFS_CTRL, 16'h0002);
        `CHK("drive_run", 1'b0, drive_run)
        @(posedge sys_clk);
        #1;
        `CHK("freq_ref", 18'h00000, freq_ref)
    endtask

    task automatic power_blip();
        @(posedge sys_clk);
        pwr_loss <= 1'b1;
        #1;
        wait_run(1'b0, 6);
        wr(`MSS_OFS_CTRL, 16'h0001);
        `CHK("drive_run", 1'b0, drive_run)
        @(posedge sys_clk);
        pwr_loss <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_regs();
        chk_rd(`MSS_OFS_MODE, 16'h0000);
        chk_rd(`MSS_OFS_RETAIN, 16'h0000);
        chk_rd(`MSS_OFS_FMAX, 16'h1388);
        chk_rd(8'h02, 16'h0000);
        chk_rd(8'h21, 16'h0000);
        chk_rd(`MSS_OFS_CTRL, 16'h0000);
        chk_rd(8'h30, 16'h0000);
        @(posedge sys_clk);
        #1;
        `CHK("rd_data", 16'h0000, rd_data)
        wr(8'h06, 16'h0BB9);
        chk_rd(8'h06, 16'h0BB8);
        wr(8'h06, 16'hF447);
        chk_rd(8'h06, 16'hF448);
        wr(8'h21, 16'hFFFF);
        chk_rd(8'h21, 16'hFFFF);
        wr(8'h21, 16'h0000);
        wr(8'h06, 16'h0000);
    endtask

    // steps 2..14 stay at zero speed and zero time, one cycle each
    task automatic load_steps();
        wr(8'h02, 16'h01F4);
        wr(8'h03, 16'h0001);
        wr(8'h04, 16'hFC18);
        wr(8'h05, 16'h0002);
        wr(8'h20, 16'hF830);
    endtask

    task automatic t_once(input logic unit_min);
        int n;
        n = 0;
        wr(`MSS_OFS_TUNIT, {15'h0000, unit_min});
        wr(`MSS_OFS_MODE, 16'h0000);
        wr(`MSS_OFS_CTRL, 16'h0001);
        `CHK("drive_run", 1'b1, drive_run)
        @(posedge sys_clk);
        #1;
        `CHK("freq_ref", 18'h009C4, freq_ref)
        `CHK("rev_dir", 1'b0, rev_dir)
        while (n < 20 && freq_ref === 18'h009C4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("step0_len", 1'b1, unit_min ? (n >= 7 && n <= 10) : (n >= 3 && n <= 6))
        `CHK("freq_ref", 18'h01388, freq_ref)
        `CHK("rev_dir", 1'b1, rev_dir)
        wait_run(1'b0, 60);
        @(posedge sys_clk);
        #1;
        `CHK("freq_ref", 18'h00000, freq_ref)
        repeat (40) @(posedge sys_clk);
        #1;
        `CHK("drive_run", 1'b0, drive_run)
    endtask

    task automatic t_hold();
        wr(`MSS_OFS_MODE, 16'h0001);
        wr(`MSS_OFS_CTRL, 16'h0001);
        wait_out(18'h02710, 1'b1, 60);
        repeat (40) @(posedge sys_clk);
        #1;
        `CHK("drive_run", 1'b1, drive_run)
        `CHK("freq_ref", 18'h02710, freq_ref)
        rd(`MSS_OFS_STATUS);
        `CHK("hold_flag", 1'b1, rv[5])
        stop_chk();
    endtask

    task automatic t_cyclic(input mss_word_t m);
        wr(`MSS_OFS_MODE, m);
        wr(`MSS_OFS_CTRL, 16'h0001);
        wait_out(18'h01388, 1'b1, 40);
        wait_out(18'h02710, 1'b1, 40);
        wait_out(18'h009C4, 1'b0, 6);
        `CHK("drive_run", 1'b1, drive_run)
        stop_chk();
    endtask

    task automatic t_retain();
        wr(`MSS_OFS_RETAIN, 16'h0001);
        wr(`MSS_OFS_MODE, 16'h0000);
        wr(`MSS_OFS_CTRL, 16'h0001);
        wait_out(18'h01388, 1'b1, 20);
        power_blip();
        rd(`MSS_OFS_STATUS);
        `CHK("kept_step", 4'h1, rv[3:0])
        `CHK("resume_flag", 1'b1, rv[6])
        run_cmd();
        wait_out(18'h01388, 1'b1, 0);
        wait_run(1'b0, 60);
        wr(`MSS_OFS_RETAIN, 16'h0000);
        wr(`MSS_OFS_CTRL, 16'h0001);
        wait_out(18'h01388, 1'b1, 20);
        power_blip();
        rd(`MSS_OFS_STATUS);
        `CHK("kept_step", 4'h0, rv[3:0])
        `CHK("resume_flag", 1'b0, rv[6])
        run_cmd();
        wait_out(18'h009C4, 1'b0, 0);
        stop_chk();
    endtask

    task automatic t_fmax();
        wr(`MSS_OFS_FMAX, 16'h0FA0);
        chk_rd(`MSS_OFS_FMAX, 16'h0FA0);
        wr(`MSS_OFS_MODE, 16'h0001);
        wr(`MSS_OFS_CTRL, 16'h0001);
        wait_out(18'h007D0, 1'b0, 8);
        wait_out(18'h01F40, 1'b1, 60);
        stop_chk();
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        load_steps();
        t_once(1'b1);
        t_once(1'b0);
        t_hold();
        t_cyclic(16'h0002);
        t_cyclic(16'h0003);
        t_retain();
        t_fmax();
        end_of_test();
    end
endmodule
